// ### design/psr_pkg.sv
package psr_pkg;
  // register addresses (16-bit register units)
  localparam logic [15:0] ADDR_FAULT_LOW = 16'h0200;
  localparam logic [15:0] ADDR_FAULT_HIGH = 16'h0202;
  localparam logic [15:0] ADDR_PRESS_COMP = 16'h0204;
  localparam logic [15:0] ADDR_TEMP_COMP = 16'h0206;
  localparam logic [15:0] ADDR_GAS_A = 16'h020A;
  localparam logic [15:0] ADDR_GAS_A_DRY = 16'h020B;
  localparam logic [15:0] ADDR_VAPOR = 16'h020C;
  localparam logic [15:0] ADDR_DEW_FROST = 16'h020D;
  localparam logic [15:0] ADDR_SENSOR_TEMP = 16'h020E;
  localparam logic [15:0] ADDR_SEVERITY = 16'h020F;
  localparam logic [15:0] ADDR_LOG_CLEAR = 16'h0210;
  localparam logic [15:0] ADDR_AUX_LEVEL = 16'h0211;
  localparam logic [15:0] ADDR_AUX_VALUE = 16'h0213;
  localparam logic [15:0] LOG_CLEAR_KEY = 16'h0001;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // measurement state codes
  localparam logic [15:0] MS_UNSUPPORTED = 16'h0000;
  localparam logic [15:0] MS_UNRELIABLE = 16'h0001;
  localparam logic [15:0] MS_UNDER_RANGE = 16'h0002;
  localparam logic [15:0] MS_OVER_RANGE = 16'h0003;
  localparam logic [15:0] MS_NOISY = 16'h0004;
  localparam logic [15:0] MS_LOCKED = 16'h0005;
  localparam logic [15:0] MS_CAL_EXPIRED = 16'h0006;
  localparam logic [15:0] MS_SENSOR_FAIL = 16'h0007;
  localparam logic [15:0] MS_NOT_READY = 16'h0008;
  // severity codes
  localparam logic [15:0] SEV_CRITICAL = 16'h0000;
  localparam logic [15:0] SEV_ERROR = 16'h0001;
  localparam logic [15:0] SEV_WARNING = 16'h0002;
  localparam logic [15:0] SEV_NOTIFY = 16'h0003;
  // low word codes
  localparam logic [31:0] FC_FW_CHECKSUM = 32'h0000_0000;
  localparam logic [31:0] FC_SETTINGS = 32'h0000_0001;
  localparam logic [31:0] FC_IR_HOT_A = 32'h0000_0009;
  localparam logic [31:0] FC_IR_HOT_B = 32'h0000_0024;
  localparam logic [31:0] FC_SUPPLY_V = 32'h0000_0012;
  localparam logic [31:0] FC_AUX_RANGE = 32'h0000_0028;
  localparam logic [31:0] FC_POWER_LOW = 32'h0000_0031;
  // high word codes
  localparam logic [31:0] FC_IR_RANGE_A = 32'h0000_0042;
  localparam logic [31:0] FC_IR_RANGE_B = 32'h0000_0044;
  localparam logic [31:0] FC_CAL_EXPIRED = 32'h0000_0039;
  localparam logic [31:0] FC_CAL_NEAR = 32'h0000_0049;
  localparam logic [31:0] FC_NONE = 32'h0000_0000;
  // identification objects
  localparam logic [7:0] OBJ_VERSION = 8'h02;
  localparam logic [7:0] OBJ_SERIAL = 8'h80;
  localparam logic [7:0] OBJ_CAL_TEXT = 8'h82;
  localparam int ID_DEPTH = 64;
  localparam int ID_AW = 6;
  // identification text slots (16 chars each)
  localparam logic [1:0] SLOT_VERSION = 2'h0;
  localparam logic [1:0] SLOT_SERIAL = 2'h1;
  localparam logic [1:0] SLOT_CAL_TEXT = 2'h2;
endpackage

// ### design/psr_id_mem.sv
`timescale 1ns/1ps
// identification text store, registered read
module psr_id_mem (
  // clock
  input wire logic clk_sys,
  // load port
  input wire logic wr_en,
  input wire logic [psr_pkg::ID_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [psr_pkg::ID_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [psr_pkg::ID_DEPTH];

  // no reset on the array; contents come from the loader
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### design/psr_regs.sv
`timescale 1ns/1ps
// What this block does
// - low status word 0x0200 holds 32-bit critical and error codes
// - high status word 0x0202 holds 32-bit warning and info codes
// - each measurement state register gives a code 0 to 8
// - overall severity: 0 critical, 1 error, 2 warning, 3 notify
// - writing 1 to 0x0210 clears the error log; other values ignored
// - reading 0x0210 always gives zero
// - pressure compensation value in use readable at 0x0204
// - temperature compensation value in use readable at 0x0206
// - hot infrared source reported as code 0x0009 or 0x0024
// - supply voltage out of range reported as 0x0012
// - analog input out of range reported as 0x0028
// - supply power too low reported as 0x0031
// - infrared source temp out of range as 0x0042 or 0x0044
// - calibration near expiry 0x0049 info, expired 0x0039 warning
// - object 2 returns firmware version text
// - object 128 returns serial number text
// - object 130 returns calibration text
module psr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register access from the protocol engine
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // identification object read
  input wire logic id_rd,
  input wire logic [7:0] id_obj,
  input wire logic [3:0] id_char,
  output logic [7:0] id_data,
  output logic id_ack,
  output logic id_err,
  // identification text loader
  input wire logic id_load,
  input wire logic [psr_pkg::ID_AW-1:0] id_load_addr,
  input wire logic [7:0] id_load_data,
  // condition inputs from the measurement core
  input wire logic fw_checksum_bad,
  input wire logic settings_bad,
  input wire logic ir_hot,
  input wire logic ir_hot_alt,
  input wire logic supply_v_bad,
  input wire logic aux_range_bad,
  input wire logic power_low,
  input wire logic ir_temp_range,
  input wire logic ir_temp_range_alt,
  input wire logic cal_expired,
  input wire logic cal_near_expiry,
  // measurement states, compensation and analog readbacks
  input wire logic [15:0] gas_a_state,
  input wire logic [15:0] gas_a_dry_state,
  input wire logic [15:0] vapor_state,
  input wire logic [15:0] dew_frost_point_state,
  input wire logic [15:0] sensor_temperature_state,
  input wire logic [31:0] pressure_comp,
  input wire logic [31:0] temperature_comp,
  input wire logic [31:0] aux_level,
  input wire logic [31:0] aux_value,
  // error log clear pulse to the log keeper
  output logic log_clear
);
  typedef struct packed {
    logic [31:0] fault_code_low_word;
    logic [31:0] fault_code_high_word;
    logic [15:0] overall_severity;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic clear;
    logic id_pend;
    logic id_bad;
    logic id_ack;
    logic id_err;
    logic hold_ok;
    logic [15:0] hold_addr;
    logic [15:0] hold_lo;
  } psr_state_type;

  psr_state_type q;
  psr_state_type next_q;
  logic [psr_pkg::ID_AW-1:0] id_addr;
  logic [7:0] id_mem_data;
  logic id_known;
  logic pair_base;
  logic [15:0] pair_lo;

  // clamp a state code; anything beyond 8 reads as unreliable
  function automatic logic [15:0] psr_state_code(input logic [15:0] c);
    if (c > psr_pkg::MS_NOT_READY) begin
      return psr_pkg::MS_UNRELIABLE;
    end
    return c;
  endfunction

  // pick word of a 32-bit value; lo clear (the pair's base address) gives the high half
  function automatic logic [15:0] psr_half(input logic [31:0] v,
                                           input logic lo);
    return lo ? v[15:0] : v[31:16];
  endfunction

  // object id to text slot
  always_comb begin
    id_known = 1'b1;
    id_addr = {psr_pkg::SLOT_VERSION, id_char};
    unique case (id_obj)
      psr_pkg::OBJ_VERSION: begin
        id_addr = {psr_pkg::SLOT_VERSION, id_char};
      end
      psr_pkg::OBJ_SERIAL: begin
        id_addr = {psr_pkg::SLOT_SERIAL, id_char};
      end
      psr_pkg::OBJ_CAL_TEXT: begin
        id_addr = {psr_pkg::SLOT_CAL_TEXT, id_char};
      end
      default: begin
        id_known = 1'b0;
      end
    endcase
  end

  psr_id_mem u_id_mem (
    .clk_sys(clk_sys),
    .wr_en(id_load),
    .wr_addr(id_load_addr),
    .wr_data(id_load_data),
    .rd_addr(id_addr),
    .rd_data(id_mem_data)
  );

  // first register of each 32-bit pair and the low half it carries
  always_comb begin
    pair_base = 1'b1;
    pair_lo = 16'h0000;
    unique case (reg_addr)
      psr_pkg::ADDR_FAULT_LOW: begin
        pair_lo = q.fault_code_low_word[15:0];
      end
      psr_pkg::ADDR_FAULT_HIGH: begin
        pair_lo = q.fault_code_high_word[15:0];
      end
      psr_pkg::ADDR_PRESS_COMP: begin
        pair_lo = pressure_comp[15:0];
      end
      psr_pkg::ADDR_TEMP_COMP: begin
        pair_lo = temperature_comp[15:0];
      end
      psr_pkg::ADDR_AUX_LEVEL: begin
        pair_lo = aux_level[15:0];
      end
      psr_pkg::ADDR_AUX_VALUE: begin
        pair_lo = aux_value[15:0];
      end
      default: begin
        pair_base = 1'b0;
      end
    endcase
  end

  // status words, severity and register answers
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.err = 1'b0;
    next_q.clear = 1'b0;
    next_q.id_ack = 1'b0;
    next_q.id_err = 1'b0;
    // low word: most severe active condition wins
    next_q.fault_code_low_word = psr_pkg::FC_NONE;
    if (power_low) begin
      next_q.fault_code_low_word = psr_pkg::FC_POWER_LOW;
    end else if (aux_range_bad) begin
      next_q.fault_code_low_word = psr_pkg::FC_AUX_RANGE;
    end else if (supply_v_bad) begin
      next_q.fault_code_low_word = psr_pkg::FC_SUPPLY_V;
    end else if (ir_hot_alt) begin
      next_q.fault_code_low_word = psr_pkg::FC_IR_HOT_B;
    end else if (ir_hot) begin
      next_q.fault_code_low_word = psr_pkg::FC_IR_HOT_A;
    end
    // critical conditions override the error codes
    if (settings_bad) begin
      next_q.fault_code_low_word = psr_pkg::FC_SETTINGS;
    end else if (fw_checksum_bad) begin
      next_q.fault_code_low_word = psr_pkg::FC_FW_CHECKSUM;
    end
    // high word: warnings ahead of info
    next_q.fault_code_high_word = psr_pkg::FC_NONE;
    if (cal_near_expiry) begin
      next_q.fault_code_high_word = psr_pkg::FC_CAL_NEAR;
    end
    if (cal_expired) begin
      next_q.fault_code_high_word = psr_pkg::FC_CAL_EXPIRED;
    end
    if (ir_temp_range_alt) begin
      next_q.fault_code_high_word = psr_pkg::FC_IR_RANGE_B;
    end else if (ir_temp_range) begin
      next_q.fault_code_high_word = psr_pkg::FC_IR_RANGE_A;
    end
    // overall severity from the worst active condition
    next_q.overall_severity = psr_pkg::SEV_NOTIFY;
    if (cal_expired || ir_temp_range || ir_temp_range_alt) begin
      next_q.overall_severity = psr_pkg::SEV_WARNING;
    end
    if (ir_hot || ir_hot_alt || supply_v_bad || aux_range_bad ||
        power_low) begin
      next_q.overall_severity = psr_pkg::SEV_ERROR;
    end
    if (fw_checksum_bad || settings_bad) begin
      next_q.overall_severity = psr_pkg::SEV_CRITICAL;
    end
    // register read
    if (reg_rd) begin
      next_q.ack = 1'b1;
      next_q.rdata = psr_pkg::READ_ZERO;
      unique case (reg_addr)
        psr_pkg::ADDR_FAULT_LOW, psr_pkg::ADDR_FAULT_LOW + 16'h0001: begin
          next_q.rdata = psr_half(q.fault_code_low_word,
                                  reg_addr[0]);
        end
        psr_pkg::ADDR_FAULT_HIGH, psr_pkg::ADDR_FAULT_HIGH + 16'h0001:
        begin
          next_q.rdata = psr_half(q.fault_code_high_word,
                                  reg_addr[0]);
        end
        psr_pkg::ADDR_PRESS_COMP, psr_pkg::ADDR_PRESS_COMP + 16'h0001:
        begin
          next_q.rdata = psr_half(pressure_comp, reg_addr[0]);
        end
        psr_pkg::ADDR_TEMP_COMP, psr_pkg::ADDR_TEMP_COMP + 16'h0001: begin
          next_q.rdata = psr_half(temperature_comp, reg_addr[0]);
        end
        psr_pkg::ADDR_GAS_A: begin
          next_q.rdata = psr_state_code(gas_a_state);
        end
        psr_pkg::ADDR_GAS_A_DRY: begin
          next_q.rdata = psr_state_code(gas_a_dry_state);
        end
        psr_pkg::ADDR_VAPOR: begin
          next_q.rdata = psr_state_code(vapor_state);
        end
        psr_pkg::ADDR_DEW_FROST: begin
          next_q.rdata = psr_state_code(dew_frost_point_state);
        end
        psr_pkg::ADDR_SENSOR_TEMP: begin
          next_q.rdata = psr_state_code(sensor_temperature_state);
        end
        psr_pkg::ADDR_SEVERITY: begin
          next_q.rdata = q.overall_severity;
        end
        psr_pkg::ADDR_LOG_CLEAR: begin
          next_q.rdata = psr_pkg::READ_ZERO;
        end
        psr_pkg::ADDR_AUX_LEVEL, psr_pkg::ADDR_AUX_LEVEL + 16'h0001: begin
          next_q.rdata = psr_half(aux_level, ~reg_addr[0]);
        end
        psr_pkg::ADDR_AUX_VALUE, psr_pkg::ADDR_AUX_VALUE + 16'h0001: begin
          next_q.rdata = psr_half(aux_value, ~reg_addr[0]);
        end
        default: begin
          next_q.err = 1'b1; // unmapped: exception answer
        end
      endcase
      // a source may move between the two halves; the next read after
      // a base, if it is base+1, gets the half held then: no torn pair
      if (q.hold_ok && reg_addr == q.hold_addr) begin
        next_q.rdata = q.hold_lo;
      end
      next_q.hold_ok = pair_base;
      next_q.hold_addr = reg_addr + 16'h0001;
      next_q.hold_lo = pair_lo;
    end else if (reg_wr) begin
      // only the clear function takes writes; others are read-only
      next_q.ack = 1'b1;
      if (reg_addr == psr_pkg::ADDR_LOG_CLEAR) begin
        next_q.clear = (reg_wdata == psr_pkg::LOG_CLEAR_KEY);
      end else begin
        next_q.err = 1'b1;
      end
    end
    // identification: memory has one cycle of read latency
    next_q.id_pend = id_rd;
    next_q.id_bad = id_rd && !id_known;
    if (q.id_pend) begin
      next_q.id_ack = 1'b1;
      next_q.id_err = q.id_bad;
    end
  end

  // single state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = q.rdata;
  assign reg_ack = q.ack;
  assign reg_err = q.err;
  assign log_clear = q.clear;
  assign id_ack = q.id_ack;
  assign id_err = q.id_err;
  assign id_data = id_mem_data;
endmodule

// ### tb/psr_regs_monitor.sv
`timescale 1ns/1ps
// port-level checks on the status register bank
module psr_regs_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register access
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic log_clear,
  // identification and conditions
  input wire logic id_rd,
  input wire logic [7:0] id_obj,
  input wire logic id_ack,
  input wire logic id_err,
  input wire logic settings_bad,
  input wire logic fw_checksum_bad,
  input wire logic power_low
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // request shapes; read wins when both are up
  sequence s_req; reg_rd || reg_wr; endsequence
  sequence s_wr; reg_wr && !reg_rd; endsequence
  sequence s_key; s_wr ##0 reg_addr == 16'h0210 && reg_wdata == 16'h0001;
  endsequence
  // conditions must settle for three edges: status is sampled, then read
  sequence s_crit; settings_bad [*3]; endsequence
  sequence s_pwr; (power_low && !settings_bad && !fw_checksum_bad) [*3];
  endsequence
  a_ack_follows: assert property (s_req |=> reg_ack)
    else $error("ack missing after request");
  a_ack_idle: assert property (!(reg_rd || reg_wr) |=> !reg_ack)
    else $error("ack without request");
  a_clear_key: assert property (s_key |=> log_clear && !reg_err)
    else $error("clear key not honoured");
  a_clear_cause: assert property (log_clear |->
    $past(reg_wr && !reg_rd && reg_addr == 16'h0210 && reg_wdata == 16'h0001))
    else $error("clear without key write");
  a_clear_reads0: assert property (reg_rd && reg_addr == 16'h0210
    |=> reg_rdata == 16'h0000 && !reg_err) else $error("clear reg not zero");
  a_ro_refused: assert property (s_wr ##0 reg_addr != 16'h0210
    |=> reg_err && !log_clear) else $error("write to read-only taken");
  a_sev_range: assert property (reg_rd && reg_addr == 16'h020F
    |=> reg_rdata <= 16'h0003) else $error("severity out of range");
  a_state_range: assert property (reg_rd && reg_addr >= 16'h020A
    && reg_addr <= 16'h020E |=> reg_rdata <= 16'h0008)
    else $error("state code out of range");
  a_crit_sev: assert property (s_crit ##0 reg_rd && reg_addr == 16'h020F
    |=> reg_rdata == 16'h0000) else $error("critical not severity 0");
  a_low_power: assert property (s_pwr ##0 reg_rd && reg_addr == 16'h0201
    |=> reg_rdata == 16'h0031) else $error("power low code wrong");
  a_id_answer: assert property (id_rd |-> ##2 id_ack)
    else $error("id answer late");
  a_id_unknown: assert property (id_rd && !(id_obj inside
    {8'h02, 8'h80, 8'h82}) |-> ##2 id_err) else $error("unknown id taken");
endmodule
bind psr_regs psr_regs_monitor mon_u (.*);

// ### tb/psr_master.sv
`timescale 1ns/1ps
// protocol engine model: one pulsed request, answer taken next cycle
module psr_master (
  // clock
  input wire logic clk_sys,
  // requests
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  // answers
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic log_clear
);
  // idle at time zero
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // idle address and data are inverted so stale values cannot pass
  task automatic xfer(input logic w, input logic [15:0] a, d,
    output logic [15:0] q, output logic [2:0] f);
    @(negedge clk_sys);
    reg_rd <= !w;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clk_sys);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    q = reg_rdata;
    f = {reg_ack, reg_err, log_clear};
  endtask
  // 32-bit value: base holds bits 31:16, base+1 bits 15:0
  task automatic rd32(input logic [15:0] a, output logic [31:0] v);
    logic [2:0] f;
    xfer(1'b0, a, 16'h0000, v[31:16], f);
    xfer(1'b0, a + 16'h0001, 16'h0000, v[15:0], f);
  endtask
endmodule

// ### tb/probe_status_register_map_bench.sv
`timescale 1ns/1ps
module probe_status_register_map_bench;
  logic clk_sys, rst, reg_rd, reg_wr, reg_ack, reg_err, log_clear;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic id_rd, id_ack, id_err, id_load;
  logic [7:0] id_obj, id_data, id_load_data;
  logic [3:0] id_char;
  logic [5:0] id_load_addr;
  logic fw_checksum_bad, settings_bad, ir_hot, ir_hot_alt, supply_v_bad;
  logic aux_range_bad, power_low, ir_temp_range, ir_temp_range_alt;
  logic cal_expired, cal_near_expiry;
  logic [15:0] gas_a_state, gas_a_dry_state, vapor_state;
  logic [15:0] dew_frost_point_state, sensor_temperature_state;
  logic [31:0] pressure_comp, temperature_comp, aux_level, aux_value;
  int miscompares, checks_done;
  typedef struct packed {
    logic [10:0] c;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] sev;
  } psr_row_type;
  // conditions fw..cal_near, then low word, high word, severity
  psr_row_type rows [12] = '{
    '{11'h000, 16'h0000, 16'h0000, 16'h0003},
    '{11'h100, 16'h0009, 16'h0000, 16'h0001},
    '{11'h180, 16'h0024, 16'h0000, 16'h0001},
    '{11'h1C0, 16'h0012, 16'h0000, 16'h0001},
    '{11'h060, 16'h0028, 16'h0000, 16'h0001},
    '{11'h070, 16'h0031, 16'h0000, 16'h0001},
    '{11'h008, 16'h0000, 16'h0042, 16'h0002},
    '{11'h00C, 16'h0000, 16'h0044, 16'h0002},
    '{11'h003, 16'h0000, 16'h0039, 16'h0002},
    '{11'h001, 16'h0000, 16'h0049, 16'h0003},
    '{11'h630, 16'h0001, 16'h0000, 16'h0000},
    '{11'h408, 16'h0000, 16'h0042, 16'h0000}};
  logic [7:0] objs [4] = '{8'h02, 8'h80, 8'h82, 8'h81};
  psr_regs dut_u (.*);
  psr_master master_u (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // id data follows the address, so object and index stay put until read
  task automatic id_get(input logic [7:0] o, output logic [7:0] q,
    output logic [1:0] g);
    @(negedge clk_sys);
    id_rd <= 1'b1;
    id_obj <= o;
    id_char <= 4'h5;
    @(negedge clk_sys);
    id_rd <= 1'b0;
    @(negedge clk_sys);
    q = id_data;
    g = {id_ack, id_err};
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
  // main sequence
  initial begin
    logic [15:0] q;
    logic [31:0] w;
    logic [2:0] f;
    logic [7:0] d;
    logic [1:0] g;
    rst = 1'b1;
    {id_rd, id_load, id_obj, id_char} = 14'h0000;
    id_load_addr = 6'h00;
    id_load_data = 8'h00;
    {fw_checksum_bad, settings_bad, ir_hot, ir_hot_alt, supply_v_bad,
      aux_range_bad, power_low, ir_temp_range, ir_temp_range_alt,
      cal_expired, cal_near_expiry} = 11'h000;
    {gas_a_state, gas_a_dry_state, vapor_state} = 48'h0;
    {dew_frost_point_state, sensor_temperature_state} = 32'h0;
    pressure_comp = 32'h4120_0000;
    temperature_comp = 32'h41C8_0000;
    aux_level = 32'h4080_0000;
    aux_value = 32'h4248_0000;
    repeat (10) @(negedge clk_sys);
    chk({reg_ack, reg_err, log_clear, id_ack, id_err}, 0);
    rst <= 1'b0;
    // three text slots of sixteen characters
    for (int i = 0; i < 48; i++) begin
      @(negedge clk_sys);
      id_load <= 1'b1;
      id_load_addr <= i[5:0];
      id_load_data <= 8'h41 + i[7:0];
    end
    @(negedge clk_sys);
    id_load <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      {fw_checksum_bad, settings_bad, ir_hot, ir_hot_alt, supply_v_bad,
        aux_range_bad, power_low, ir_temp_range, ir_temp_range_alt,
        cal_expired, cal_near_expiry} <= rows[i].c;
      repeat (3) @(negedge clk_sys);
      master_u.rd32(16'h0200, w);
      chk(w, {16'h0000, rows[i].lo});
      master_u.rd32(16'h0202, w);
      chk(w, {16'h0000, rows[i].hi});
      master_u.xfer(1'b0, 16'h020F, 16'h0000, q, f);
      chk({f, q}, {3'b100, rows[i].sev});
    end
    $display("test done: status rows");
    // every state code, plus one above the range
    for (int k = 0; k < 10; k++) begin
      {gas_a_state, gas_a_dry_state, vapor_state} <= {3{k[15:0]}};
      {dew_frost_point_state, sensor_temperature_state} <= {2{k[15:0]}};
      repeat (2) @(negedge clk_sys);
      for (int a = 0; a < 5; a++) begin
        master_u.xfer(1'b0, 16'h020A + a[15:0], 16'h0000, q, f);
        chk(q, (k > 8) ? 1 : k);
      end
    end
    $display("test done: state codes");
    master_u.rd32(16'h0204, w);
    chk(w, 32'h4120_0000);
    master_u.rd32(16'h0206, w);
    chk(w, 32'h41C8_0000);
    master_u.rd32(16'h0211, w);
    chk(w, 32'h4080_0000);
    master_u.rd32(16'h0213, w);
    chk(w, 32'h4248_0000);
    // a pair cannot tear: base+1 after its base gives the held half
    master_u.xfer(1'b0, 16'h0204, 16'h0000, q, f);
    pressure_comp <= 32'h4120_5555;
    master_u.xfer(1'b0, 16'h0205, 16'h0000, q, f);
    chk(q, 16'h0000);
    master_u.xfer(1'b0, 16'h0205, 16'h0000, q, f);
    chk(q, 16'h5555);
    $display("test done: values in use");
    // clear key, near misses, read-back, read-only and unmapped places
    master_u.xfer(1'b1, 16'h0210, 16'h0001, q, f);
    chk(f, 3'b101);
    master_u.xfer(1'b1, 16'h0210, 16'h0002, q, f);
    chk(f, 3'b100);
    master_u.xfer(1'b1, 16'h0210, 16'h0101, q, f);
    chk(f, 3'b100);
    master_u.xfer(1'b0, 16'h0210, 16'h0000, q, f);
    chk({f, q}, {3'b100, 16'h0000});
    master_u.xfer(1'b1, 16'h0200, 16'h0001, q, f);
    chk(f, 3'b110);
    master_u.xfer(1'b0, 16'h0208, 16'h0000, q, f);
    chk({f, q}, {3'b110, 16'h0000});
    $display("test done: log clear and refusals");
    for (int i = 0; i < 4; i++) begin
      id_get(objs[i], d, g);
      chk(g, (i == 3) ? 2'b11 : 2'b10);
      if (i < 3) begin
        chk(d, 8'h46 + 8'h10 * i[7:0]);
      end
    end
    $display("test done: identification");
    // mid-run reset with power low: answers drop, live status returns
    fw_checksum_bad <= 1'b0;
    ir_temp_range <= 1'b0;
    power_low <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({reg_rdata, reg_ack, reg_err, log_clear, id_ack, id_err}, 0);
    rst <= 1'b0;
    master_u.xfer(1'b0, 16'h0201, 16'h0000, q, f);
    chk({f, q}, {3'b100, 16'h0031});
    master_u.xfer(1'b0, 16'h020F, 16'h0000, q, f);
    chk({f, q}, {3'b100, 16'h0001});
    $display("test done: mid-run reset");
    close_out();
  end
endmodule
